// ### verilog/ldc_consts.vh
// Function
// - brightness follows pwm input duty after reset; host may select its own level
// - open-drain interrupt pin pulled low while an unmasked fault is pending
// - pending status cleared by host clear pulse or enable falling edge
// - per-channel 12-bit host field scales the strap current limit
// - string count decoded from strap; phase step is 360 over that count
// - channels above the string count are off and raise no led fault
// - sync input checked at start-up; external clock used if seen, else internal
// - static high sync enables spread spectrum, static low disables it
// - boost frequency chosen from the eight-entry strap decode table
// - internal blocks powered only while enable is high
// - host interface and fault detection inactive while enable is low
// - charge pump enabled unless pump pin detected tied to supply
// - flycap flag and pump fault flag reported while pump enabled
// - pump irq enable gates pump fault onto interrupt, status still sets
// - any strap code out of range raises a strap fault
// - twelve fault kinds over 21 status bits detected and held separately
// - dimming mode decoded from mode strap
// - dimming pwm frequency decoded from its strap
// - current drivers start a nominal 50 ms after boost soft-start begins
`ifndef LDC_CONSTS_VH
`define LDC_CONSTS_VH
`define LDC_CLK_MHZ 250
`define LDC_CLK_NS 4
`define LDC_TSTART_MS 50
`define LDC_TSTART_CYC (`LDC_TSTART_MS * 1000 * `LDC_CLK_MHZ)
`define LDC_SYNC_WIN_NS 2000
`define LDC_SYNC_WIN_CYC ((`LDC_SYNC_WIN_NS + `LDC_CLK_NS - 1) / `LDC_CLK_NS)
`define LDC_SYNC_MIN_EDGES 4'h2
`define LDC_STRAP_MAX 4'h7
`define LDC_STRING_MAX 4'h3
`define LDC_MODE_MAX 4'h3
`define LDC_HOST_PERIOD 20'h0_FFFF
`define LDC_FULL_SCALE 12'hFFF
`define LDC_FLT_OPEN 0
`define LDC_FLT_SHORT 4
`define LDC_FLT_GND 8
`define LDC_FLT_BOCP 12
`define LDC_FLT_BOVP 13
`define LDC_FLT_VDDUV 14
`define LDC_FLT_VINOV 15
`define LDC_FLT_VINUV 16
`define LDC_FLT_VINOC 17
`define LDC_FLT_TSD 18
`define LDC_FLT_STRAP 19
`define LDC_FLT_PUMP 20
`define LDC_FLT_W 21
`endif

// ### verilog/ldc_core.v
`timescale 1ns/100ps
`default_nettype none
`include "ldc_consts.vh"

module ldc_core #(
   parameter [23:0] TSTART_CYC = `LDC_TSTART_CYC
) (
   input wire clk,
   input wire sys_rst,
   input wire clk_en,
   input wire enable_pin,
   input wire pwm_pin,
   input wire boost_sync_input,
   input wire [3:0] boost_freq_strap,
   input wire [3:0] dim_freq_strap,
   input wire [3:0] current_limit_strap,
   input wire [3:0] string_count_strap,
   input wire [3:0] mode_strap,
   input wire [3:0] led_open_raw,
   input wire [3:0] led_short_raw,
   input wire [3:0] led_gnd_raw,
   input wire [6:0] supply_fault_raw,
   input wire pump_tied_raw,
   input wire flycap_det_raw,
   input wire pump_fault_raw,
   input wire host_dim_sel,
   input wire [15:0] host_brightness,
   input wire [47:0] chan_current_scale,
   input wire pump_irq_enable,
   input wire host_clear,
   output wire irq_pin_out,
   output wire irq_pin_oe,
   output reg [`LDC_FLT_W-1:0] fault_status,
   output reg flycap_present_flag,
   output reg pump_fault_flag,
   output reg power_up,
   output reg host_if_active,
   output reg pump_enable,
   output reg boost_run,
   output reg drivers_on,
   output reg boost_ext_clk_sel,
   output reg spread_spectrum_en,
   output reg [11:0] boost_freq_khz,
   output reg [2:0] dim_freq_sel,
   output reg [1:0] dim_mode_sel,
   output reg [2:0] current_limit_sel,
   output reg [2:0] string_count,
   output reg [8:0] phase_step,
   output reg [35:0] chan_phase,
   output reg [3:0] chan_active,
   output reg [47:0] chan_current,
   output reg brightness_src_host,
   output reg [19:0] dim_high_cnt,
   output reg [19:0] dim_period_cnt
);

   localparam [1:0] ST_OFF = 2'b00;
   localparam [1:0] ST_SAMPLE = 2'b01;
   localparam [1:0] ST_SOFT = 2'b10;
   localparam [1:0] ST_RUN = 2'b11;
   localparam [23:0] SYNC_WIN = `LDC_SYNC_WIN_CYC;

   function [11:0] boost_khz;
      input [2:0] code;
      begin
         case (code)
            3'h0: boost_khz = 12'd400;
            3'h1: boost_khz = 12'd200;
            3'h2: boost_khz = 12'd303;
            3'h3: boost_khz = 12'd100;
            3'h4: boost_khz = 12'd500;
            3'h5: boost_khz = 12'd1818;
            3'h6: boost_khz = 12'd2000;
            default: boost_khz = 12'd2222;
         endcase
      end
   endfunction

   function [8:0] step_deg;
      input [1:0] code;
      begin
         case (code)
            2'h0: step_deg = 9'd360;
            2'h1: step_deg = 9'd180;
            2'h2: step_deg = 9'd120;
            default: step_deg = 9'd90;
         endcase
      end
   endfunction

   // two flip-flop synchronisers for every pin and analog comparator input
   reg [29:0] sync1_reg;
   reg [29:0] sync2_reg;
   wire [29:0] async_in = {enable_pin, pwm_pin, boost_sync_input, led_open_raw,
      led_short_raw, led_gnd_raw, supply_fault_raw, pump_tied_raw,
      flycap_det_raw, pump_fault_raw, 5'h00};
   wire en_s = sync2_reg[29];
   wire pwm_s = sync2_reg[28];
   wire bsync_s = sync2_reg[27];
   wire [3:0] open_s = sync2_reg[26:23];
   wire [3:0] short_s = sync2_reg[22:19];
   wire [3:0] gnd_s = sync2_reg[18:15];
   wire [6:0] supply_s = sync2_reg[14:8];
   wire tied_s = sync2_reg[7];
   wire flycap_s = sync2_reg[6];
   wire pfault_s = sync2_reg[5];
   // straps are static, yet still pins, so they get the same two flops
   reg [19:0] strap1_reg;
   reg [19:0] strap2_reg;
   wire [3:0] bfreq_s = strap2_reg[19:16];
   wire [3:0] dfreq_s = strap2_reg[15:12];
   wire [3:0] ilim_s = strap2_reg[11:8];
   wire [3:0] strings_s = strap2_reg[7:4];
   wire [3:0] mode_s = strap2_reg[3:0];

   always @(posedge clk) begin
      if (sys_rst) begin
         sync1_reg <= 30'h0;
         sync2_reg <= 30'h0;
         strap1_reg <= 20'h0_0000;
         strap2_reg <= 20'h0_0000;
      end else if (clk_en) begin
         sync1_reg <= async_in;
         sync2_reg <= sync1_reg;
         strap1_reg <= {boost_freq_strap, dim_freq_strap, current_limit_strap,
            string_count_strap, mode_strap};
         strap2_reg <= strap1_reg;
      end
   end

   reg en_d_reg;
   reg pwm_d_reg;
   reg bsync_d_reg;
   wire en_fall = en_d_reg & ~en_s;
   wire pwm_rise = pwm_s & ~pwm_d_reg;
   wire bsync_rise = bsync_s & ~bsync_d_reg;

   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [23:0] cnt_reg;
   reg [3:0] edge_cnt_reg;

   wire strap_bad = (bfreq_s > `LDC_STRAP_MAX) | (dfreq_s > `LDC_STRAP_MAX) |
      (ilim_s > `LDC_STRAP_MAX) | (strings_s > `LDC_STRING_MAX) |
      (mode_s > `LDC_MODE_MAX);

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_OFF: if (en_s) state_next = ST_SAMPLE;
         ST_SAMPLE: if (cnt_reg == SYNC_WIN - 24'h1) state_next = ST_SOFT;
         ST_SOFT: if (cnt_reg == TSTART_CYC - 24'h1) state_next = ST_RUN;
         default: state_next = ST_RUN;
      endcase
      if (!en_s) state_next = ST_OFF;
   end

   // straps are latched at the end of the sampling window only
   wire sample_done = (state_reg == ST_SAMPLE) && (state_next == ST_SOFT);
   reg strap_bad_reg;

   always @(posedge clk) begin
      if (sys_rst) begin
         state_reg <= ST_OFF;
         cnt_reg <= 24'h0;
         edge_cnt_reg <= 4'h0;
         en_d_reg <= 1'b0;
         pwm_d_reg <= 1'b0;
         bsync_d_reg <= 1'b0;
         power_up <= 1'b0;
         host_if_active <= 1'b0;
         boost_run <= 1'b0;
         drivers_on <= 1'b0;
         boost_ext_clk_sel <= 1'b0;
         spread_spectrum_en <= 1'b0;
         pump_enable <= 1'b0;
         boost_freq_khz <= 12'h000;
         dim_freq_sel <= 3'h0;
         dim_mode_sel <= 2'h0;
         current_limit_sel <= 3'h0;
         string_count <= 3'h0;
         phase_step <= 9'h000;
         chan_active <= 4'h0;
         strap_bad_reg <= 1'b0;
      end else if (clk_en) begin
         en_d_reg <= en_s;
         pwm_d_reg <= pwm_s;
         bsync_d_reg <= bsync_s;
         state_reg <= state_next;
         cnt_reg <= (state_next != state_reg) ? 24'h0 : cnt_reg + 24'h1;
         power_up <= en_s;
         host_if_active <= en_s;
         boost_run <= (state_next == ST_SOFT) | (state_next == ST_RUN);
         drivers_on <= (state_next == ST_RUN);
         if (state_reg != ST_SAMPLE)
            edge_cnt_reg <= 4'h0;
         else if (bsync_rise && edge_cnt_reg != 4'hF)
            edge_cnt_reg <= edge_cnt_reg + 4'h1;
         if (state_next == ST_OFF) begin
            boost_ext_clk_sel <= 1'b0;
            spread_spectrum_en <= 1'b0;
            pump_enable <= 1'b0;
            chan_active <= 4'h0;
            strap_bad_reg <= 1'b0;
         end else if (sample_done) begin
            // a clock seen in the window wins; otherwise the static level picks spread
            boost_ext_clk_sel <= (edge_cnt_reg >= `LDC_SYNC_MIN_EDGES);
            spread_spectrum_en <= (edge_cnt_reg < `LDC_SYNC_MIN_EDGES) & bsync_s;
            pump_enable <= ~tied_s;
            boost_freq_khz <= boost_khz(bfreq_s[2:0]);
            dim_freq_sel <= dfreq_s[2:0];
            dim_mode_sel <= mode_s[1:0];
            current_limit_sel <= ilim_s[2:0];
            string_count <= {1'b0, strings_s[1:0]} + 3'h1;
            phase_step <= step_deg(strings_s[1:0]);
            chan_active <= ~(4'hE << strings_s[1:0]);
            strap_bad_reg <= strap_bad;
         end
      end
   end

   // per-channel phase offsets as multiples of the step
   integer i;
   reg [35:0] phase_next;
   always @* begin
      phase_next = 36'h0;
      for (i = 1; i < 4; i = i + 1)
         phase_next[i*9 +: 9] = phase_next[(i-1)*9 +: 9] + phase_step;
      for (i = 0; i < 4; i = i + 1)
         if (!chan_active[i])
            phase_next[i*9 +: 9] = 9'h000;
   end

   // brightness: pwm duty measured in clk cycles, or host level over fixed period
   reg [19:0] hi_cnt_reg;
   reg [19:0] per_cnt_reg;
   wire host_mode = host_dim_sel & host_if_active;
   integer c;
   always @(posedge clk) begin
      if (sys_rst) begin
         hi_cnt_reg <= 20'h0_0000;
         per_cnt_reg <= 20'h0_0000;
         dim_high_cnt <= 20'h0_0000;
         dim_period_cnt <= 20'h0_0000;
         brightness_src_host <= 1'b0;
         chan_phase <= 36'h0;
         chan_current <= 48'h0;
      end else if (clk_en) begin
         brightness_src_host <= host_mode;
         chan_phase <= phase_next;
         for (c = 0; c < 4; c = c + 1)
            chan_current[c*12 +: 12] <= !chan_active[c] ? 12'h000 :
               host_if_active ? chan_current_scale[c*12 +: 12] : `LDC_FULL_SCALE;
         if (pwm_rise) begin
            // the rising-edge cycle is itself high time
            hi_cnt_reg <= 20'h0_0001;
            per_cnt_reg <= 20'h0_0001;
         end else begin
            if (per_cnt_reg != 20'hF_FFFF)
               per_cnt_reg <= per_cnt_reg + 20'h0_0001;
            if (pwm_s && hi_cnt_reg != 20'hF_FFFF)
               hi_cnt_reg <= hi_cnt_reg + 20'h0_0001;
         end
         if (host_mode) begin
            dim_high_cnt <= {4'h0, host_brightness};
            dim_period_cnt <= `LDC_HOST_PERIOD;
         end else if (pwm_rise) begin
            dim_high_cnt <= hi_cnt_reg;
            dim_period_cnt <= per_cnt_reg;
         end
      end
   end

   // sticky fault status; a new event beats a clear in the same cycle
   wire [`LDC_FLT_W-1:0] fault_evt;
   wire det_on = en_s & (state_reg != ST_OFF);
   assign fault_evt[`LDC_FLT_OPEN +: 4] = open_s & chan_active & {4{det_on}};
   assign fault_evt[`LDC_FLT_SHORT +: 4] = short_s & chan_active & {4{det_on}};
   assign fault_evt[`LDC_FLT_GND +: 4] = gnd_s & chan_active & {4{det_on}};
   assign fault_evt[`LDC_FLT_TSD:`LDC_FLT_BOCP] = supply_s & {7{det_on}};
   assign fault_evt[`LDC_FLT_STRAP] = strap_bad_reg & det_on;
   assign fault_evt[`LDC_FLT_PUMP] = pfault_s & pump_enable & det_on;
   wire clr = (host_clear & host_if_active) | en_fall;

   reg [`LDC_FLT_W-1:0] irq_mask;
   always @* begin
      irq_mask = {`LDC_FLT_W{1'b1}};
      irq_mask[`LDC_FLT_PUMP] = pump_irq_enable;
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         fault_status <= {`LDC_FLT_W{1'b0}};
         flycap_present_flag <= 1'b0;
         pump_fault_flag <= 1'b0;
      end else if (clk_en) begin
         fault_status <= (clr ? {`LDC_FLT_W{1'b0}} : fault_status) | fault_evt;
         flycap_present_flag <= pump_enable & flycap_s & det_on;
         pump_fault_flag <= clr ? fault_evt[`LDC_FLT_PUMP] :
            (pump_fault_flag | fault_evt[`LDC_FLT_PUMP]);
      end
   end

   // open drain: pin only ever driven low
   assign irq_pin_out = 1'b0;
   assign irq_pin_oe = |(fault_status & irq_mask);

endmodule // ldc_core
`default_nettype wire

// ### tb/ldc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module ldc_host_model (
   input wire logic clk,
   input wire logic sync_on,
   input wire logic sync_lvl,
   input wire logic [15:0] pwm_hi,
   input wire logic [15:0] pwm_per,
   output var logic pwm_pin,
   output var logic boost_sync_input
);
   int ph = 0;
   always @(posedge clk) begin
      ph <= (ph + 1 >= pwm_per) ? 0 : ph + 1;
      pwm_pin <= ph < pwm_hi;
   end
   // 48 ns sync clock off the bench clock phase; static strap level between frames
   initial begin
      boost_sync_input = 1'b0;
      #7;
      forever #24 boost_sync_input = sync_on ? ~boost_sync_input : sync_lvl;
   end
endmodule // ldc_host_model
`default_nettype wire

// ### tb/ldc_core_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "ldc_consts.vh"
module ldc_core_props #(
   parameter [23:0] TSTART_CYC = `LDC_TSTART_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic pump_irq_enable,
   input wire logic host_clear,
   input wire logic irq_pin_out,
   input wire logic irq_pin_oe,
   input wire logic [`LDC_FLT_W-1:0] fault_status,
   input wire logic power_up,
   input wire logic pump_enable,
   input wire logic boost_run,
   input wire logic drivers_on,
   input wire logic boost_ext_clk_sel,
   input wire logic spread_spectrum_en,
   input wire logic [2:0] string_count,
   input wire logic [8:0] phase_step,
   input wire logic [3:0] chan_active
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic [23:0] run_cnt_reg;
   // saturates so a stuck boost never wraps into a false pass
   always @(posedge clk) begin
      if (sys_rst || !boost_run) run_cnt_reg <= 24'h00_0000;
      else if (clk_en && run_cnt_reg != 24'hff_ffff) run_cnt_reg <= run_cnt_reg + 24'h00_0001;
   end
   a_irq_open_drain: assert property (irq_pin_out == 1'b0)
      else $error("irq pin driven high");
   a_irq_pending: assert property (fault_status[19:0] != 20'h0_0000 |-> irq_pin_oe)
      else $error("irq not pulled with status set");
   a_pump_gate: assert property (irq_pin_oe |-> fault_status[19:0] != 20'h0_0000 ||
      (fault_status[20] && (pump_irq_enable || $past(pump_irq_enable)))) else $error("irq spurious");
   a_status_sticky: assert property (power_up && $past(power_up) && !$past(host_clear)
      |-> (fault_status & $past(fault_status)) == $past(fault_status)) else $error("status lost");
   a_off_no_new: assert property (!power_up && !$past(power_up)
      |-> (fault_status & ~$past(fault_status)) == 21'h00_0000) else $error("fault set while off");
   a_off_quiet: assert property (!power_up && !$past(power_up) && !$past(power_up, 2)
      |-> !drivers_on && !boost_run) else $error("running while off");
   a_led_masked: assert property (power_up |-> ((fault_status[3:0] | fault_status[7:4] |
      fault_status[11:8]) & ~chan_active) == 4'h0) else $error("fault on unused channel");
   a_phase_step: assert property (power_up && string_count != 3'h0 ##1 power_up &&
      $stable(string_count) |-> phase_step == 9'h168 / string_count) else $error("phase step");
   a_start_delay: assert property ($rose(drivers_on) |-> run_cnt_reg + 24'h00_0008 >= TSTART_CYC
      && run_cnt_reg <= TSTART_CYC + 24'h00_0008) else $error("driver start delay");
   a_pump_status: assert property ($rose(fault_status[20]) |-> pump_enable)
      else $error("pump fault without pump");
   a_clock_mode: assert property (spread_spectrum_en |-> !boost_ext_clk_sel)
      else $error("spread with external clock");
   c_drivers: cover property ($rose(drivers_on));
   c_pump_masked: cover property (fault_status[20] && !irq_pin_oe);
   c_ext_clk: cover property ($rose(boost_ext_clk_sel));
endmodule // ldc_core_props
bind ldc_core ldc_core_props #(.TSTART_CYC(TSTART_CYC)) u_props (.clk, .sys_rst, .clk_en,
   .pump_irq_enable, .host_clear, .irq_pin_out, .irq_pin_oe, .fault_status, .power_up,
   .pump_enable, .boost_run, .drivers_on, .boost_ext_clk_sel, .spread_spectrum_en,
   .string_count, .phase_step, .chan_active);
`default_nettype wire

// ### tb/ldc_core_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "ldc_consts.vh"
module ldc_core_bench;
   logic clk, sys_rst, clk_en, enable_pin, pwm_pin, boost_sync_input, sync_on, sync_lvl;
   logic [3:0] boost_freq_strap, dim_freq_strap, current_limit_strap, string_count_strap;
   logic [3:0] mode_strap, led_open_raw, led_short_raw, led_gnd_raw, chan_active;
   logic [6:0] supply_fault_raw;
   logic pump_tied_raw, flycap_det_raw, pump_fault_raw, host_dim_sel, pump_irq_enable, host_clear;
   logic [15:0] host_brightness;
   logic [47:0] chan_current_scale, chan_current;
   logic irq_pin_out, irq_pin_oe, flycap_present_flag, pump_fault_flag, power_up, host_if_active;
   logic pump_enable, boost_run, drivers_on, boost_ext_clk_sel, spread_spectrum_en;
   logic brightness_src_host;
   logic [`LDC_FLT_W-1:0] fault_status;
   logic [11:0] boost_freq_khz;
   logic [2:0] dim_freq_sel, current_limit_sel, string_count;
   logic [1:0] dim_mode_sel;
   logic [8:0] phase_step;
   logic [35:0] chan_phase;
   logic [19:0] dim_high_cnt, dim_period_cnt;
   logic [31:0] r;
   int mismatches = 0, total_checks = 0, cycles = 0, seed = 32'h0000_1f60, i, n;
   int fk[8] = '{400, 200, 303, 100, 500, 1818, 2000, 2222};
   ldc_core #(.TSTART_CYC(24'h00_00c8)) dut (.clk, .sys_rst, .clk_en, .enable_pin, .pwm_pin,
      .boost_sync_input, .boost_freq_strap, .dim_freq_strap, .current_limit_strap,
      .string_count_strap, .mode_strap, .led_open_raw, .led_short_raw, .led_gnd_raw,
      .supply_fault_raw, .pump_tied_raw, .flycap_det_raw, .pump_fault_raw, .host_dim_sel,
      .host_brightness, .chan_current_scale, .pump_irq_enable, .host_clear, .irq_pin_out,
      .irq_pin_oe, .fault_status, .flycap_present_flag, .pump_fault_flag, .power_up,
      .host_if_active, .pump_enable, .boost_run, .drivers_on, .boost_ext_clk_sel,
      .spread_spectrum_en, .boost_freq_khz, .dim_freq_sel, .dim_mode_sel, .current_limit_sel,
      .string_count, .phase_step, .chan_phase, .chan_active, .chan_current,
      .brightness_src_host, .dim_high_cnt, .dim_period_cnt);
   ldc_host_model host (.clk, .sync_on, .sync_lvl, .pwm_hi(16'h0007), .pwm_per(16'h0014),
      .pwm_pin, .boost_sync_input);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic conclude;
      if (mismatches == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // sm: 0 sync tied low, 1 tied high, 2 external clock during the sample window
   task automatic start(input logic [3:0] bf, input logic [3:0] cs, input int sm);
      boost_freq_strap <= bf;
      dim_freq_strap <= bf;
      current_limit_strap <= cs;
      string_count_strap <= bf & 4'h3;
      mode_strap <= bf & 4'h3;
      pump_tied_raw <= bf[2];
      sync_on <= (sm == 2);
      sync_lvl <= (sm == 1);
      enable_pin <= 1'b1;
      cyc(1);
      repeat (20) if (!power_up) cyc(1);
      cyc(510);
      sync_on <= 1'b0;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         conclude;
      end
   end
   initial begin
      {sys_rst, clk_en, sync_on, sync_lvl, enable_pin, host_dim_sel, host_clear} = 7'h60;
      {pump_tied_raw, flycap_det_raw, pump_fault_raw, pump_irq_enable} = 4'h0;
      {boost_freq_strap, dim_freq_strap, current_limit_strap, string_count_strap} = 16'h0000;
      {mode_strap, led_open_raw, led_short_raw, led_gnd_raw, supply_fault_raw} = 23'h00_0000;
      host_brightness = 16'h0000;
      chan_current_scale = 48'h0000_0000_0000;
      cyc(4);
      sys_rst <= 1'b0;
      cyc(2);
      chk(fault_status, 0);
      for (i = 0; i < 9; i++) begin
         n = (i & 3) + 1;
         start(i[3:0] & 4'h7, i == 8 ? 4'h9 : i[3:0], i % 3);
         chk(boost_freq_khz, fk[i & 7]);
         chk({string_count, phase_step, chan_active}, {n[2:0], 9'(360 / n), 4'((1 << n) - 1)});
         chk(chan_phase[17:9], n > 1 ? 360 / n : 0);
         chk({boost_ext_clk_sel, spread_spectrum_en}, {i % 3 == 2, i % 3 == 1});
         chk({dim_mode_sel, dim_freq_sel}, {i[1:0], i[2:0]});
         chk({pump_enable, host_if_active}, {!i[2], 1'b1});
         chk(fault_status[19], i == 8);
         if (i < 8) chk(current_limit_sel, i);
         enable_pin <= 1'b0;
         cyc(8);
         chk({power_up, chan_active, fault_status}, 0);
      end
      flycap_det_raw <= 1'b1;
      start(4'h1, 4'h2, 0);
      repeat (260) if (!drivers_on) cyc(1);
      chk(drivers_on, 1);
      chk({dim_high_cnt, dim_period_cnt}, {20'h0_0007, 20'h0_0014});
      r = $random(seed);
      {led_open_raw, led_short_raw, led_gnd_raw, supply_fault_raw} <= {4'hf, r[7:0], r[14:8]};
      cyc(1);
      {led_open_raw, led_short_raw, led_gnd_raw, supply_fault_raw} <= 19'h0_0000;
      cyc(5);
      chk(fault_status, {2'b0, r[14:8], 2'b0, r[1:0], 2'b0, r[5:4], 4'h3});
      chk(irq_pin_oe, 1);
      host_clear <= 1'b1;
      cyc(1);
      host_clear <= 1'b0;
      cyc(2);
      chk({fault_status, irq_pin_oe, flycap_present_flag}, 1);
      pump_fault_raw <= 1'b1;
      cyc(1);
      pump_fault_raw <= 1'b0;
      cyc(5);
      chk({fault_status, irq_pin_oe, pump_fault_flag}, 23'h40_0001);
      pump_irq_enable <= 1'b1;
      cyc(3);
      chk(irq_pin_oe, 1);
      r = $random(seed);
      {host_brightness, chan_current_scale, host_dim_sel} <= {r[15:0], r[31:16], r, 1'b1};
      cyc(6);
      chk({brightness_src_host, dim_high_cnt, dim_period_cnt}, {5'h10, r[15:0], 20'h0_ffff});
      chk(chan_current, {24'h00_0000, r[23:0]});
      // a frozen clock enable must hold off a fault until it is released
      clk_en <= 1'b0;
      led_open_raw <= 4'hf;
      cyc(6);
      chk(fault_status[3:0], 4'h0);
      clk_en <= 1'b1;
      cyc(1);
      led_open_raw <= 4'h0;
      cyc(5);
      chk(fault_status[3:0], 4'h3);
      enable_pin <= 1'b0;
      cyc(8);
      chk({fault_status, irq_pin_oe, pump_fault_flag}, 0);
      conclude;
   end
endmodule // ldc_core_bench
`default_nettype wire
